// ==== core/ccic_top.sv ====
// Purpose: Context-cache invalidate command register with invalidation sequencer
// Assumes: AXI4-Lite slave, single clock, synchronous active-low reset
// Notes: Invalidation engine is modelled by a cycle count and match outputs
// Function
// - Granularity code written with request flag
// - Hardware may invalidate coarser than asked
// - Completion shown by clearing request flag
// - Performed granularity updated at completion
// - Global may answer any request
// - Domain performed only for domain/device
// - Device performed only for device requests
// - Function mask hides low function bits
// - Requester id selects device entry
// - Id and mask read back undefined
// - Tag bits above width N ignored
// - Address and command registers 8 apart
// - Extended capability advertises address offset
// - Top byte write with flag starts
// - Flush write buffer first if required
//
// Chosen here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/100ps
module ccic_top #(
  parameter int DOMAIN_W = 8,
  parameter bit WRITE_FLUSH_REQ = 1'b1,
  parameter bit DEVICE_GRAN_OK = 1'b1,
  parameter bit DOMAIN_GRAN_OK = 1'b1
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [ccic_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ccic_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic wb_flush_req,
  output logic inval_active,
  output ccic_pkg::ccic_req_t inval_cmd,
  output logic [15:0] match_mask
);

  // The width code is a four-bit field, so sixteen cannot be reported
  if (DOMAIN_W < 4 || DOMAIN_W > 15) begin : g_bad_domain_w
    $error("DOMAIN_W must be 4..15");
  end

  typedef enum logic [1:0] {ST_IDLE, ST_FLUSH, ST_INVAL} ccic_state_t;

  // Tag bits above the supported width are neither stored nor returned
  localparam logic [15:0] DTAG_KEEP = 16'((32'h1 << DOMAIN_W) - 1);

  function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction

  // Coarsen a request to what this implementation supports
  function automatic ccic_pkg::ccic_gran_t perf_gran(input ccic_pkg::ccic_gran_t g);
    ccic_pkg::ccic_gran_t r;
    r = ccic_pkg::CCIC_G_GLOBAL;
    if (g == ccic_pkg::CCIC_G_DEVICE && DEVICE_GRAN_OK) r = ccic_pkg::CCIC_G_DEVICE;
    else if ((g == ccic_pkg::CCIC_G_DEVICE || g == ccic_pkg::CCIC_G_DOMAIN) && DOMAIN_GRAN_OK)
      r = ccic_pkg::CCIC_G_DOMAIN;
    return r;
  endfunction

  // Write channel state
  logic aw_held_q, aw_held_d, w_held_q, w_held_d, bvalid_q, bvalid_d;
  logic [7:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic [1:0] bresp_q, bresp_d;
  // Read channel state
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;
  // Register state
  logic [15:0] dtag_q, dtag_d;
  logic [15:0] rid_q, rid_d;
  logic [1:0] fmask_q, fmask_d;
  ccic_pkg::ccic_gran_t rgran_q, rgran_d, pgran_q, pgran_d;
  logic req_q, req_d;
  logic [31:0] fta_lo_q, fta_lo_d, fta_hi_q, fta_hi_d, tic_lo_q, tic_lo_d, tic_hi_q, tic_hi_d;
  ccic_state_t st_q, st_d;
  logic [7:0] cnt_q, cnt_d;
  logic wbf_q, wbf_d, act_q, act_d;
  ccic_pkg::ccic_req_t cmd_q, cmd_d;
  logic [15:0] mmask_q, mmask_d;
  // Readies registered so that every port leaves a flip-flop
  logic awrdy_q, awrdy_d, wrdy_q, wrdy_d, arrdy_q, arrdy_d;

  logic wr_fire;
  logic [31:0] lo_merged;
  logic [31:0] cap_lo, ecap_lo;
  logic [31:0] ccmd_hi_rd, ccmd_lo_rd;

  // Response waits for both halves; the next write stalls behind bvalid
  assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
  assign lo_merged = strb_merge({rid_q, dtag_q}, wdata_q, wstrb_q);
  // Capability low word: flush-required flag and domain width code
  assign cap_lo = {27'h0, WRITE_FLUSH_REQ, 4'(DOMAIN_W)};
  assign ecap_lo = {14'h0, 10'(ccic_pkg::FTA_BASE_OFF >> 4), 8'h0};
  assign ccmd_hi_rd = {req_q, rgran_q, pgran_q, 25'h0, 2'h0};
  // Id and mask are write-only; zero is returned for them
  assign ccmd_lo_rd = {16'h0, dtag_q & DTAG_KEEP};

  always_comb begin
    aw_held_d = aw_held_q;
    w_held_d = w_held_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    dtag_d = dtag_q;
    rid_d = rid_q;
    fmask_d = fmask_q;
    rgran_d = rgran_q;
    pgran_d = pgran_q;
    req_d = req_q;
    fta_lo_d = fta_lo_q;
    fta_hi_d = fta_hi_q;
    tic_lo_d = tic_lo_q;
    tic_hi_d = tic_hi_q;
    st_d = st_q;
    cnt_d = cnt_q;
    wbf_d = 1'b0;
    act_d = 1'b0;
    cmd_d = cmd_q;
    mmask_d = mmask_q;
    if (s_axi_awvalid && !aw_held_q) begin
      aw_held_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_held_q) begin
      w_held_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (bvalid_q && s_axi_bready) bvalid_d = 1'b0;
    // Invalidation sequencer
    unique case (st_q)
      ST_IDLE: begin
      end
      ST_FLUSH: begin
        // Buffered writes must drain before any entry is dropped
        wbf_d = 1'b1;
        if (cnt_q == 8'h0) begin
          st_d = ST_INVAL;
          cnt_d = ccic_pkg::INVAL_CYC - 8'h1;
        end else begin
          cnt_d = cnt_q - 8'h1;
        end
      end
      ST_INVAL: begin
        act_d = 1'b1;
        if (cnt_q == 8'h0) begin
          st_d = ST_IDLE;
          act_d = 1'b0;
          req_d = 1'b0;
          pgran_d = cmd_q.gran;
        end else begin
          cnt_d = cnt_q - 8'h1;
        end
      end
    endcase
    if (wr_fire) begin
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = ccic_pkg::RESP_OKAY;
      unique case (awaddr_q)
        ccic_pkg::CCMD_LO_OFF: begin
          if (!req_q) begin
            dtag_d = lo_merged[15:0] & DTAG_KEEP;
            rid_d = lo_merged[31:16];
          end
        end
        ccic_pkg::CCMD_HI_OFF: begin
          if (!req_q) begin
            if (wstrb_q[0]) fmask_d = wdata_q[1:0];
            if (wstrb_q[3]) begin
              rgran_d = ccic_pkg::ccic_gran_t'(wdata_q[ccic_pkg::RG_LSB_HI +: 2]);
              if (wdata_q[ccic_pkg::REQ_BIT_HI]) begin
                req_d = 1'b1;
                // Operands frozen here; the flag blocks later command writes
                cmd_d.gran = perf_gran(ccic_pkg::ccic_gran_t'(wdata_q[ccic_pkg::RG_LSB_HI +: 2]));
                cmd_d.domain_tag = dtag_q;
                cmd_d.requester_id = rid_q;
                cmd_d.function_mask = wstrb_q[0] ? wdata_q[1:0] : fmask_q;
                // Phantom functions: clear the low id bits that the mask covers
                mmask_d = 16'hffff;
                for (int b = 0; b < 3; b++) begin
                  if (cmd_d.function_mask > 2'(b)) mmask_d[2 - b] = 1'b0;
                end
                if (WRITE_FLUSH_REQ) begin
                  st_d = ST_FLUSH;
                  cnt_d = ccic_pkg::WB_FLUSH_CYC - 8'h1;
                end else begin
                  st_d = ST_INVAL;
                  cnt_d = ccic_pkg::INVAL_CYC - 8'h1;
                end
              end
            end
          end
        end
        // Address and translation command words are storage only
        ccic_pkg::FTA_LO_OFF: fta_lo_d = strb_merge(fta_lo_q, wdata_q, wstrb_q);
        ccic_pkg::FTA_HI_OFF: fta_hi_d = strb_merge(fta_hi_q, wdata_q, wstrb_q);
        ccic_pkg::TIC_LO_OFF: tic_lo_d = strb_merge(tic_lo_q, wdata_q, wstrb_q);
        ccic_pkg::TIC_HI_OFF: tic_hi_d = strb_merge(tic_hi_q, wdata_q, wstrb_q);
        ccic_pkg::CAP_LO_OFF, ccic_pkg::CAP_HI_OFF, ccic_pkg::ECAP_LO_OFF, ccic_pkg::ECAP_HI_OFF: begin
        end
        default: bresp_d = ccic_pkg::RESP_SLVERR;
      endcase
    end
    // Read answered the cycle after the address is taken
    if (rvalid_q && s_axi_rready) rvalid_d = 1'b0;
    if (s_axi_arvalid && !rvalid_q) begin
      rvalid_d = 1'b1;
      rresp_d = ccic_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        ccic_pkg::CAP_LO_OFF: rdata_d = cap_lo;
        ccic_pkg::CAP_HI_OFF: rdata_d = 32'h0;
        ccic_pkg::ECAP_LO_OFF: rdata_d = ecap_lo;
        ccic_pkg::ECAP_HI_OFF: rdata_d = 32'h0;
        ccic_pkg::CCMD_LO_OFF: rdata_d = ccmd_lo_rd;
        ccic_pkg::CCMD_HI_OFF: rdata_d = ccmd_hi_rd;
        ccic_pkg::FTA_LO_OFF: rdata_d = fta_lo_q;
        ccic_pkg::FTA_HI_OFF: rdata_d = fta_hi_q;
        ccic_pkg::TIC_LO_OFF: rdata_d = tic_lo_q;
        ccic_pkg::TIC_HI_OFF: rdata_d = tic_hi_q;
        default: begin
          rdata_d = 32'h0;
          rresp_d = ccic_pkg::RESP_SLVERR;
        end
      endcase
    end
    awrdy_d = !aw_held_d;
    wrdy_d = !w_held_d;
    arrdy_d = !rvalid_d;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 8'h0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= 2'h0;
      dtag_q <= 16'h0;
      rid_q <= 16'h0;
      fmask_q <= 2'h0;
      rgran_q <= ccic_pkg::CCIC_G_RSVD;
      pgran_q <= ccic_pkg::CCIC_G_RSVD;
      req_q <= 1'b0;
      fta_lo_q <= 32'h0;
      fta_hi_q <= 32'h0;
      tic_lo_q <= 32'h0;
      tic_hi_q <= 32'h0;
      st_q <= ST_IDLE;
      cnt_q <= 8'h0;
      wbf_q <= 1'b0;
      act_q <= 1'b0;
      cmd_q <= '0;
      mmask_q <= 16'h0;
      awrdy_q <= 1'b1;
      wrdy_q <= 1'b1;
      arrdy_q <= 1'b1;
    end else begin
      aw_held_q <= aw_held_d;
      w_held_q <= w_held_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      dtag_q <= dtag_d;
      rid_q <= rid_d;
      fmask_q <= fmask_d;
      rgran_q <= rgran_d;
      pgran_q <= pgran_d;
      req_q <= req_d;
      fta_lo_q <= fta_lo_d;
      fta_hi_q <= fta_hi_d;
      tic_lo_q <= tic_lo_d;
      tic_hi_q <= tic_hi_d;
      st_q <= st_d;
      cnt_q <= cnt_d;
      wbf_q <= wbf_d;
      act_q <= act_d;
      cmd_q <= cmd_d;
      mmask_q <= mmask_d;
      awrdy_q <= awrdy_d;
      wrdy_q <= wrdy_d;
      arrdy_q <= arrdy_d;
    end
  end

  // Channel readies taken from registers; holding stage absorbs one item
  assign s_axi_awready = awrdy_q;
  assign s_axi_wready = wrdy_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arrdy_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign wb_flush_req = wbf_q;
  assign inval_active = act_q;
  assign inval_cmd = cmd_q;
  assign match_mask = mmask_q;

endmodule

// ==== core/ccic_pkg.sv ====
// Purpose: Shared constants and types for the context-cache invalidate command block
// Assumes: AXI4-Lite with 32-bit data, one aligned word per register half
// Notes: 64-bit registers occupy two words, low word first
package ccic_pkg;

  localparam int ADDR_W = 8;

  // Byte addresses of register words
  localparam logic [7:0] CAP_LO_OFF = 8'h08;
  localparam logic [7:0] CAP_HI_OFF = 8'h0c;
  localparam logic [7:0] ECAP_LO_OFF = 8'h10;
  localparam logic [7:0] ECAP_HI_OFF = 8'h14;
  localparam logic [7:0] CCMD_LO_OFF = 8'h28;
  localparam logic [7:0] CCMD_HI_OFF = 8'h2c;
  localparam logic [7:0] FTA_BASE_OFF = 8'h40;
  localparam logic [7:0] TIC_DELTA_OFF = 8'h08;
  localparam logic [7:0] FTA_LO_OFF = FTA_BASE_OFF;
  localparam logic [7:0] FTA_HI_OFF = FTA_BASE_OFF + 8'h04;
  localparam logic [7:0] TIC_LO_OFF = FTA_BASE_OFF + TIC_DELTA_OFF;
  localparam logic [7:0] TIC_HI_OFF = FTA_BASE_OFF + TIC_DELTA_OFF + 8'h04;

  // Field positions within the high word of the command register
  localparam int REQ_BIT_HI = 31;
  localparam int RG_LSB_HI = 29;
  localparam int PG_LSB_HI = 27;
  localparam int FM_LSB_HI = 0;
  // Field positions within the low word
  localparam int RID_LSB_LO = 16;
  localparam int DTAG_LSB_LO = 0;
  // Capability: write-flush-required at bit 4, domain width code at 3:0
  localparam int WFR_BIT = 4;
  // Extended capability: address-register offset field at bits 17:8, in 16-byte units
  localparam int AOF_LSB = 8;

  // Cycle counts of the invalidation engine
  localparam logic [7:0] WB_FLUSH_CYC = 8'h04;
  localparam logic [7:0] INVAL_CYC = 8'h08;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    CCIC_G_RSVD = 2'h0,
    CCIC_G_GLOBAL = 2'h1,
    CCIC_G_DOMAIN = 2'h2,
    CCIC_G_DEVICE = 2'h3
  } ccic_gran_t;

  typedef struct packed {
    ccic_gran_t gran;
    logic [15:0] domain_tag;
    logic [15:0] requester_id;
    logic [1:0] function_mask;
  } ccic_req_t;

endpackage

// ==== sim/ccic_top_sva.sv ====
// Purpose: Port assertions for the context-cache invalidate command block
// Assumes: One clock, synchronous active-low reset
// Notes: Bound to every ccic_top instance
`timescale 1ns/100ps
module ccic_top_sva (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic wb_flush_req,
  input wire logic inval_active,
  input wire ccic_pkg::ccic_req_t inval_cmd,
  input wire logic [15:0] match_mask
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  chk_flush_then_inval: assert property ($rose(wb_flush_req) |-> wb_flush_req [*4] ##1 !wb_flush_req && inval_active)
    else $error("flush phase not followed by invalidation");
  chk_inval_length: assert property ($rose(inval_active) |-> inval_active [*7] ##1 !inval_active)
    else $error("invalidation phase length wrong");
  chk_gran_legal: assert property (inval_active |-> inval_cmd.gran != ccic_pkg::CCIC_G_RSVD)
    else $error("reserved granularity performed");
  chk_fm_mask: assert property (inval_active && inval_cmd.gran == ccic_pkg::CCIC_G_DEVICE |->
    match_mask == {13'h1fff, 3'h7 >> inval_cmd.function_mask})
    else $error("function mask applied wrongly");
  chk_cmd_steady: assert property (inval_active |=> !inval_active || $stable(inval_cmd))
    else $error("operands changed during invalidation");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  chk_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered next cycle");
  chk_aw_block: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("address taken while one is held");
  cov_device: cover property (inval_active && inval_cmd.gran == ccic_pkg::CCIC_G_DEVICE);
  cov_slverr: cover property (s_axi_bvalid && s_axi_bresp == ccic_pkg::RESP_SLVERR);
  cov_done: cover property ($fell(inval_active));
endmodule

bind ccic_top ccic_top_sva u_sva (.sys_clk, .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .wb_flush_req,
  .inval_active, .inval_cmd, .match_mask);

// ==== sim/context_cache_invalidate_cmd_bench.sv ====
// Purpose: Self-checking bench for the context-cache invalidate command block
// Assumes: Default parameters, so domain tags keep 8 bits
// Notes: Random operands from a fixed seed
`timescale 1ns/100ps
module context_cache_invalidate_cmd_bench;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, wb_flush_req, inval_active;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [15:0] match_mask, cap_mask;
  ccic_pkg::ccic_req_t inval_cmd, cap_cmd;
  int miscompares = 0;
  int tests_run = 0;
  int seed = 32'h2e3dbd07;

  always #25 sys_clk = ~sys_clk;

  ccic_top uut (.sys_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .wb_flush_req, .inval_active,
    .inval_cmd, .match_mask);

  // Keep the last operands seen by the engine for later comparison
  always @(posedge sys_clk) if (inval_active) begin
    cap_cmd <= inval_cmd;
    cap_mask <= match_mask;
  end

  function automatic logic [1:0] exp_gran(input logic [1:0] g);
    return (g == 2'h0) ? 2'h1 : g;
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Ready is raised late on purpose so the slave must hold its answer
  // The wait ends only at the answer; the watchdog catches a hang
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] resp);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
    end while (!(s_axi_bvalid && s_axi_bready));
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid && s_axi_rready));
    d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (4000) @(posedge sys_clk);
    miscompares++;
    test_done;
  end

  initial begin
    logic [31:0] d, e;
    logic [1:0] r, g, fm;
    logic [15:0] tag, id;
    int n;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(ccic_pkg::CCMD_HI_OFF, d, r);
    chk("cmd hi after reset", 32'h0, d);
    rd(8'h80, d, r);
    chk("unmapped read resp", {30'h0, ccic_pkg::RESP_SLVERR}, {30'h0, r});
    wr(8'h84, 32'h1, 4'hf, r);
    chk("unmapped write resp", {30'h0, ccic_pkg::RESP_SLVERR}, {30'h0, r});
    rd(ccic_pkg::ECAP_LO_OFF, d, r);
    chk("address reg offset", 32'(ccic_pkg::FTA_BASE_OFF) >> 4, {22'h0, d[17:8]});
    rd(ccic_pkg::CAP_LO_OFF, d, r);
    chk("flush required", 32'h1, {31'h0, d[ccic_pkg::WFR_BIT]});
    d = $random(seed);
    wr(ccic_pkg::FTA_BASE_OFF + 8'h08, d, 4'hf, r);
    rd(ccic_pkg::FTA_BASE_OFF + 8'h08, e, r);
    chk("command word at base plus 8", d, e);
    wr(ccic_pkg::CCMD_HI_OFF, 32'ha0000000, 4'h7, r);
    rd(ccic_pkg::CCMD_HI_OFF, d, r);
    chk("no start without top byte", 32'h0, d & 32'h80000000);
    for (int i = 0; i < 8; i++) begin
      g = i[1:0];
      tag = 16'($random(seed));
      id = 16'($random(seed));
      fm = 2'($random(seed));
      wr(ccic_pkg::CCMD_LO_OFF, {id, tag}, 4'hf, r);
      wr(ccic_pkg::CCMD_HI_OFF, {1'b1, g, 2'h3, 25'($random(seed)), fm}, 4'hf, r);
      // Rewrite while busy must be dropped
      if (i == 5) wr(ccic_pkg::CCMD_HI_OFF, {1'b1, ~g, 29'h0}, 4'hf, r);
      n = 0;
      do begin
        rd(ccic_pkg::CCMD_HI_OFF, d, r);
        n++;
      end while (d[31] && n < 40);
      chk("cmd hi after done", {1'b0, g, exp_gran(g), 27'h0}, d & 32'hfffffffc);
      rd(ccic_pkg::CCMD_LO_OFF, d, r);
      chk("domain tag", {24'h0, tag[7:0]}, {16'h0, d[15:0]});
      chk("engine gran", {30'h0, exp_gran(g)}, {30'h0, cap_cmd.gran});
      if (g[1]) chk("engine domain tag", {24'h0, tag[7:0]}, {16'h0, cap_cmd.domain_tag});
      if (g == 2'h3) begin
        chk("requester id", {16'h0, id}, {16'h0, cap_cmd.requester_id});
        chk("match mask", {16'h0, 13'h1fff, 3'h7 >> fm}, {16'h0, cap_mask});
      end
    end
    test_done;
  end
endmodule
